// *** hw/pwm_evt_pkg.sv ***
// Constants shared by the PWM event, compare and fine-step logic.
// Assumes a 250 MHz module clock and a 32-bit APB register bus.
package pwm_evt_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;      // Control bits.
  localparam logic [7:0] DC_SEL_OFS = 8'h04;    // Compare input select.
  localparam logic [7:0] DC_POL_OFS = 8'h08;    // Compare input level.
  localparam logic [7:0] BLANK_OFS = 8'h0C;     // Blanking length.
  localparam logic [7:0] ET_CFG_OFS = 8'h10;    // Trigger channels.
  localparam logic [7:0] CMP_A_OFS = 8'h14;     // Compare value a.
  localparam logic [7:0] CMP_B_OFS = 8'h18;     // Compare value b.
  localparam logic [7:0] CMP_C_OFS = 8'h1C;     // Compare value c.
  localparam logic [7:0] CMP_D_OFS = 8'h20;     // Compare value d.
  localparam logic [7:0] PERIOD_OFS = 8'h24;    // Period value.
  localparam logic [7:0] PHASE_OFS = 8'h28;     // Phase value.
  localparam logic [7:0] STATUS_OFS = 8'h2C;    // Sticky events, read only.
  localparam logic [7:0] CLEAR_OFS = 8'h30;     // Event clear, write only.
  localparam logic [7:0] IEN_OFS = 8'h34;       // Interrupt enable.
  localparam logic [7:0] POS_OFS = 8'h38;       // Positioner scale, read only.

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_TRIP_EN = 0;    // Compare event trips outputs.
  localparam int CTRL_SYNC_EN = 1;    // Compare event syncs time base.
  localparam int CTRL_SOC_EN = 2;     // Compare event starts conversion.
  localparam int CTRL_BLANK_EN = 3;   // Blanking window in use.
  localparam int CTRL_BLANK_PRD = 4;  // Open window at period, else zero.
  localparam int CTRL_CHECK = 5;      // Write one to start self-check.
  localparam int CTRL_W = 5;          // Stored control bits.
  localparam int ET_CH_W = 12;        // Bits per trigger channel.
  localparam int ET_SEL_LSB = 0;      // Event select, 4 bits.
  localparam int ET_DIV_LSB = 4;      // Divide value, 4 bits.
  localparam int ET_EN_BIT = 8;       // Channel enable.
  localparam int FRAC_LSB = 16;       // Fraction extension position.
  localparam int ST_ET_INT = 0;       // Trigger interrupt event.
  localparam int ST_DC_TRIP = 1;      // Compare trip event.
  localparam int ST_POS_DONE = 2;     // Self-check finished.
  localparam int ST_POS_FAIL = 3;     // Self-check out of range.
  localparam int ST_W = 4;            // Sticky status width.
  localparam int ST_CNT_LSB = 8;      // Prescaler counts in status.

  // ************************************************************
  // Event select codes
  // ************************************************************
  localparam int EV_ZERO = 1;         // Counter equals zero.
  localparam int EV_PERIOD = 2;       // Counter equals period.
  localparam int EV_ZERO_PRD = 3;     // Either of the two.
  localparam int EV_CMP_BASE = 4;     // Up match a, down match a, b, c, d.
  localparam int EV_DC = 12;          // Digital-compare event.

  // ************************************************************
  // Fine-step timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 4000;  // Module clock period.
  localparam int POS_STEP_PS = 150;     // Nominal fine step.
  localparam logic [7:0] POS_NOMINAL = 8'(CLK_PERIOD_PS / POS_STEP_PS);
  localparam logic [7:0] POS_MIN = 8'h10;  // Least healthy steps per clock.
  localparam logic [7:0] POS_MAX = 8'h30;  // Most healthy steps per clock.

endpackage : pwm_evt_pkg

// *** hw/pwm_event_hires.sv ***
// Event side of a PWM unit: digital compare, event trigger with
// prescaler, interrupt logic and fine-step edge codes for the
// micro edge positioner. Assumes the time-base counter and the
// delay line sit outside, synchronous to clk_sys_i.
module pwm_event_hires (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [15:0] tb_count_i,
  input wire logic tb_tick_i,
  input wire logic tb_up_i,
  input wire logic [7:0] ext_pin_i,
  input wire logic [7:0] periph_i,
  input wire logic [7:0] pos_cal_steps_i,
  input wire logic pos_cal_valid_i,
  output logic pos_cal_start_o,
  output logic trip_o,
  output logic sync_o,
  output logic soc_o,
  output logic irq_o,
  output logic edge_a_o,
  output logic edge_b_o,
  output logic [7:0] fine_cmp_a_o,
  output logic [7:0] fine_cmp_b_o,
  output logic [7:0] fine_period_o,
  output logic [7:0] fine_phase_o
);

  // ************************************************************
  // Registers and internal signals
  // ************************************************************
  typedef enum logic [0:0] {
    CHK_IDLE,
    CHK_WAIT
  } check_state_e;

  logic [pwm_evt_pkg::CTRL_W-1:0] ctrl;  // Control bits.
  logic [15:0] dc_sel;                  // Compare input selection.
  logic [15:0] dc_pol;                  // One selects high level.
  logic [15:0] blank_len;               // Blanking length in clocks.
  logic [23:0] et_cfg;                  // Two trigger channels.
  logic [23:0] cmp_val [4];             // Coarse value and fraction.
  logic [23:0] period_val;              // Coarse period and fraction.
  logic [23:0] phase_val;               // Coarse phase and fraction.
  logic [pwm_evt_pkg::ST_W-1:0] status; // Sticky events.
  logic [pwm_evt_pkg::ST_W-1:0] ien;    // Interrupt enables.
  logic [pwm_evt_pkg::ST_W-1:0] status_set; // Events this cycle.
  logic [pwm_evt_pkg::ST_W-1:0] status_clr; // Clear strobe bits.
  logic [7:0] pos_scale;                // Measured steps per clock.
  check_state_e chk_state;              // Self-check progress.
  logic [15:0] blank_cnt;               // Remaining blanking clocks.
  logic [15:0] dc_in;                   // Crossbar inputs combined.
  logic dc_raw;                         // Unblanked compare event.
  logic dc_evt;                         // Qualified compare event.
  logic ev_zero;                        // Counter reached zero.
  logic ev_period;                      // Counter reached period.
  logic [3:0] cmp_hit;                  // Counter met compare value.
  logic [15:0] evt_vec;                 // Events by select code.
  logic [1:0] et_fire;                  // Channel outputs this cycle.
  logic [3:0] et_cnt [2];               // Prescaler counts.
  logic acc;                            // Access phase completes.
  logic wr;                             // Completing write.
  logic check_go;                       // Self-check start strobe.
  logic hit;                            // Address is mapped.
  logic [31:0] rd_mux;                  // Read data selection.

  assign acc = psel_i && penable_i && pready_o;
  assign wr = acc && pwrite_i;
  assign check_go = wr && (paddr_i == pwm_evt_pkg::CTRL_OFS) && pwdata_i[pwm_evt_pkg::CTRL_CHECK];

  // ************************************************************
  // APB slave
  // ************************************************************
  // Ready rises one cycle into the access phase; data goes with it.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
      pslverr_o <= psel_i && penable_i && !pready_o && !hit;
    end
  end

  // Read selection; write-only and unmapped words read as zero.
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      pwm_evt_pkg::CTRL_OFS: rd_mux = 32'(ctrl);
      pwm_evt_pkg::DC_SEL_OFS: rd_mux = 32'(dc_sel);
      pwm_evt_pkg::DC_POL_OFS: rd_mux = 32'(dc_pol);
      pwm_evt_pkg::BLANK_OFS: rd_mux = 32'(blank_len);
      pwm_evt_pkg::ET_CFG_OFS: rd_mux = 32'(et_cfg);
      pwm_evt_pkg::CMP_A_OFS: rd_mux = 32'(cmp_val[0]);
      pwm_evt_pkg::CMP_B_OFS: rd_mux = 32'(cmp_val[1]);
      pwm_evt_pkg::CMP_C_OFS: rd_mux = 32'(cmp_val[2]);
      pwm_evt_pkg::CMP_D_OFS: rd_mux = 32'(cmp_val[3]);
      pwm_evt_pkg::PERIOD_OFS: rd_mux = 32'(period_val);
      pwm_evt_pkg::PHASE_OFS: rd_mux = 32'(phase_val);
      pwm_evt_pkg::STATUS_OFS: begin
        rd_mux = 32'(status);
        rd_mux[pwm_evt_pkg::ST_CNT_LSB +: 8] = {et_cnt[1], et_cnt[0]};
      end
      pwm_evt_pkg::CLEAR_OFS: rd_mux = 32'h0000_0000;
      pwm_evt_pkg::IEN_OFS: rd_mux = 32'(ien);
      pwm_evt_pkg::POS_OFS: rd_mux = 32'(pos_scale);
      default: hit = 1'b0;
    endcase
  end

  // Software-written configuration takes effect at the completing edge.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl <= '0;
      dc_sel <= 16'h0000;
      dc_pol <= 16'h0000;
      blank_len <= 16'h0000;
      et_cfg <= 24'h00_0000;
      cmp_val <= '{default: 24'h00_0000};
      period_val <= 24'h00_0000;
      phase_val <= 24'h00_0000;
      ien <= '0;
    end else if (wr) begin
      case (paddr_i)
        pwm_evt_pkg::CTRL_OFS: ctrl <= pwdata_i[pwm_evt_pkg::CTRL_W-1:0];
        pwm_evt_pkg::DC_SEL_OFS: dc_sel <= pwdata_i[15:0];
        pwm_evt_pkg::DC_POL_OFS: dc_pol <= pwdata_i[15:0];
        pwm_evt_pkg::BLANK_OFS: blank_len <= pwdata_i[15:0];
        pwm_evt_pkg::ET_CFG_OFS: et_cfg <= pwdata_i[23:0];
        pwm_evt_pkg::CMP_A_OFS: cmp_val[0] <= pwdata_i[23:0];
        pwm_evt_pkg::CMP_B_OFS: cmp_val[1] <= pwdata_i[23:0];
        pwm_evt_pkg::CMP_C_OFS: cmp_val[2] <= pwdata_i[23:0];
        pwm_evt_pkg::CMP_D_OFS: cmp_val[3] <= pwdata_i[23:0];
        pwm_evt_pkg::PERIOD_OFS: period_val <= pwdata_i[23:0];
        pwm_evt_pkg::PHASE_OFS: phase_val <= pwdata_i[23:0];
        pwm_evt_pkg::IEN_OFS: ien <= pwdata_i[pwm_evt_pkg::ST_W-1:0];
        default: ;  // Read-only, clear and unmapped words store nothing.
      endcase
    end
  end

  // ************************************************************
  // Time-base and compare events
  // ************************************************************
  // Matches count only on a counter step, so a held count fires once.
  always_comb begin
    ev_zero = tb_tick_i && (tb_count_i == 16'h0000);
    ev_period = tb_tick_i && (tb_count_i == period_val[15:0]);
    for (int k = 0; k < 4; k++) begin
      cmp_hit[k] = tb_tick_i && (tb_count_i == cmp_val[k][15:0]);
    end
  end

  // Event vector indexed by the trigger select code.
  always_comb begin
    evt_vec = 16'h0000;
    evt_vec[pwm_evt_pkg::EV_ZERO] = ev_zero;
    evt_vec[pwm_evt_pkg::EV_PERIOD] = ev_period;
    evt_vec[pwm_evt_pkg::EV_ZERO_PRD] = ev_zero || ev_period;
    for (int k = 0; k < 4; k++) begin
      evt_vec[pwm_evt_pkg::EV_CMP_BASE + 2 * k] = cmp_hit[k] && tb_up_i;
      evt_vec[pwm_evt_pkg::EV_CMP_BASE + 2 * k + 1] = cmp_hit[k] && !tb_up_i;
    end
    evt_vec[pwm_evt_pkg::EV_DC] = dc_evt;
  end

  // ************************************************************
  // Digital compare
  // ************************************************************
  // Any selected input sitting at its chosen level raises the event.
  always_comb begin
    dc_in = {periph_i, ext_pin_i};
    dc_raw = |(dc_sel & ~(dc_in ^ dc_pol));
    dc_evt = dc_raw && !(ctrl[pwm_evt_pkg::CTRL_BLANK_EN] && (blank_cnt != 16'h0000));
  end

  // The window opens at the chosen switching instant and runs down.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      blank_cnt <= 16'h0000;
    end else if (ctrl[pwm_evt_pkg::CTRL_BLANK_PRD] ? ev_period : ev_zero) begin
      blank_cnt <= blank_len;
    end else if (blank_cnt != 16'h0000) begin
      blank_cnt <= blank_cnt - 16'h0001;
    end
  end

  // Compare actions towards trip, sync and conversion start.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      trip_o <= 1'b0;
      sync_o <= 1'b0;
      soc_o <= 1'b0;
    end else begin
      trip_o <= dc_evt && ctrl[pwm_evt_pkg::CTRL_TRIP_EN];
      sync_o <= dc_evt && ctrl[pwm_evt_pkg::CTRL_SYNC_EN];
      soc_o <= et_fire[1] || (dc_evt && ctrl[pwm_evt_pkg::CTRL_SOC_EN]);
    end
  end

  // ************************************************************
  // Event trigger: channel 0 interrupt, channel 1 conversion start
  // ************************************************************
  for (genvar c = 0; c < 2; c++) begin : g_et
    logic [3:0] sel;  // Event select code.
    logic [3:0] div;  // Divide value; zero disables.
    logic en;         // Channel enable.
    assign sel = et_cfg[c * pwm_evt_pkg::ET_CH_W + pwm_evt_pkg::ET_SEL_LSB +: 4];
    assign div = et_cfg[c * pwm_evt_pkg::ET_CH_W + pwm_evt_pkg::ET_DIV_LSB +: 4];
    assign en = et_cfg[c * pwm_evt_pkg::ET_CH_W + pwm_evt_pkg::ET_EN_BIT];

    // Counts qualifying events and fires on the divide value.
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        et_cnt[c] <= 4'h0;
        et_fire[c] <= 1'b0;
      end else begin
        et_fire[c] <= 1'b0;
        if (en && (div != 4'h0) && evt_vec[sel]) begin
          if (et_cnt[c] + 4'h1 >= div) begin
            et_fire[c] <= 1'b1;
            et_cnt[c] <= 4'h0;
          end else begin
            et_cnt[c] <= et_cnt[c] + 4'h1;
          end
        end
      end
    end
  end

  // ************************************************************
  // Interrupt status
  // ************************************************************
  // Event bits for this cycle and the clear strobe from software.
  always_comb begin
    status_set = '0;
    status_set[pwm_evt_pkg::ST_ET_INT] = et_fire[0];
    status_set[pwm_evt_pkg::ST_DC_TRIP] = dc_evt && ctrl[pwm_evt_pkg::CTRL_TRIP_EN];
    status_set[pwm_evt_pkg::ST_POS_DONE] = (chk_state == CHK_WAIT) && pos_cal_valid_i;
    status_set[pwm_evt_pkg::ST_POS_FAIL] = (chk_state == CHK_WAIT) && pos_cal_valid_i &&
      ((pos_cal_steps_i < pwm_evt_pkg::POS_MIN) || (pos_cal_steps_i > pwm_evt_pkg::POS_MAX));
    status_clr = (wr && (paddr_i == pwm_evt_pkg::CLEAR_OFS)) ? pwdata_i[pwm_evt_pkg::ST_W-1:0] : '0;
  end

  // A set arriving with its clear wins, so no event is lost.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      status <= '0;
      irq_o <= 1'b0;
    end else begin
      status <= (status & ~status_clr) | status_set;
      irq_o <= |(status & ien);
    end
  end

  // ************************************************************
  // Micro edge positioner self-check
  // ************************************************************
  // A start pulse asks the delay line for its steps per clock.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      chk_state <= CHK_IDLE;
      pos_cal_start_o <= 1'b0;
      pos_scale <= pwm_evt_pkg::POS_NOMINAL;
    end else begin
      pos_cal_start_o <= 1'b0;
      case (chk_state)
        CHK_IDLE: begin
          if (check_go) begin
            pos_cal_start_o <= 1'b1;
            chk_state <= CHK_WAIT;
          end
        end
        CHK_WAIT: begin
          if (pos_cal_valid_i) begin
            chk_state <= CHK_IDLE;
            if ((pos_cal_steps_i >= pwm_evt_pkg::POS_MIN) && (pos_cal_steps_i <= pwm_evt_pkg::POS_MAX)) begin
              pos_scale <= pos_cal_steps_i;
            end
          end
        end
        default: chk_state <= CHK_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Fine-step edge codes
  // ************************************************************
  // The fraction in 1/256 clock becomes a count of fine steps.
  function automatic logic [7:0] fine_steps(input logic [7:0] frac, input logic [7:0] scale);
    logic [15:0] prod;
    prod = frac * scale;
    return prod[15:8];
  endfunction : fine_steps

  // Codes and coarse edge strobes for the positioner.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fine_cmp_a_o <= 8'h00;
      fine_cmp_b_o <= 8'h00;
      fine_period_o <= 8'h00;
      fine_phase_o <= 8'h00;
      edge_a_o <= 1'b0;
      edge_b_o <= 1'b0;
    end else begin
      fine_cmp_a_o <= fine_steps(cmp_val[0][pwm_evt_pkg::FRAC_LSB +: 8], pos_scale);
      fine_cmp_b_o <= fine_steps(cmp_val[1][pwm_evt_pkg::FRAC_LSB +: 8], pos_scale);
      fine_period_o <= fine_steps(period_val[pwm_evt_pkg::FRAC_LSB +: 8], pos_scale);
      fine_phase_o <= fine_steps(phase_val[pwm_evt_pkg::FRAC_LSB +: 8], pos_scale);
      edge_a_o <= cmp_hit[0];
      edge_b_o <= cmp_hit[1];
    end
  end

endmodule : pwm_event_hires

// *** tb/pwm_event_hires_sva.sv ***
// Concurrent checks on the bus and event ports of pwm_event_hires.
// Assumes it is bound to the design and sees its ports only.
module pwm_event_hires_chk (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic tb_tick_i,
  input wire logic pos_cal_start_o,
  input wire logic trip_o,
  input wire logic sync_o,
  input wire logic soc_o,
  input wire logic irq_o,
  input wire logic edge_a_o,
  input wire logic edge_b_o
);
  // ************************************************************
  // Clock and reset for every check
  // ************************************************************
  default clocking chk_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  // A setup cycle is answered after exactly one wait state.
  ready_one_wait_a: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("Bus answer not after one wait state.");
  // The answer stands for one cycle only.
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("Bus answer held too long.");
  // An answer only comes inside an access phase.
  ready_access_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("Bus answer outside an access phase.");
  // An error flag only comes with an answer.
  error_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("Bus error without an answer.");
  // Trip, sync, conversion start, interrupt and self-check start are quiet right after reset.
  reset_quiet_a: assert property ($fell(sys_rst_i) |-> !(trip_o || sync_o || soc_o || irq_o || pos_cal_start_o))
    else $error("Output active after reset.");
  edge_a_tick_a: assert property (edge_a_o |-> $past(tb_tick_i))
    else $error("Edge a without a counter step.");
  edge_b_tick_a: assert property (edge_b_o |-> $past(tb_tick_i))
    else $error("Edge b without a counter step.");
  cal_start_pulse_a: assert property (pos_cal_start_o |=> !pos_cal_start_o)
    else $error("Self-check start held too long.");
endmodule : pwm_event_hires_chk

bind pwm_event_hires pwm_event_hires_chk chk (.clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pready_o,
  .pslverr_o, .tb_tick_i, .pos_cal_start_o, .trip_o, .sync_o, .soc_o, .irq_o, .edge_a_o, .edge_b_o);

// *** tb/pwm_mep_cal_model.sv ***
// Model of the fine-step delay line that answers a self-check.
// Assumes the bench sets the reported count and the answer delay.
module pwm_pos_cal_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] steps_i,
  input wire logic [7:0] delay_i,
  output logic [7:0] cal_steps_o,
  output logic cal_valid_o
);
  logic [7:0] wait_cnt; // Cycles left before the answer.
  logic busy; // A measurement is running.

  // measured steps reported
  // The count line toggles while idle, so a stale value is never seen.
  always_ff @(posedge clk_sys_i) begin
    cal_valid_o <= 1'b0;
    cal_steps_o <= ~cal_steps_o;
    if (rst_i) begin
      busy <= 1'b0;
      cal_steps_o <= 8'h00;
    end else if (start_i) begin
      busy <= 1'b1;
      wait_cnt <= delay_i;
    end else if (busy && wait_cnt == 8'h00) begin
      busy <= 1'b0;
      cal_valid_o <= 1'b1;
      cal_steps_o <= steps_i;
    end else if (busy) begin
      wait_cnt <= wait_cnt - 8'h01;
    end
  end
endmodule : pwm_pos_cal_model

// *** tb/pwm_event_hires_test.sv ***
// Self-checking bench for pwm_event_hires over its APB port.
// Assumes the counter and crossbar inputs are driven from here.
module pwm_event_hires_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00, ext_pin_i = 8'hFE, periph_i = 8'hFF, cal_want = 8'h1C, cal_wait = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [15:0] tb_count_i = 16'h0, cnt;
  logic tb_tick_i = 1'b0, tb_up_i = 1'b1, up, err, pos_cal_valid_i, pos_cal_start_o, pready_o, pslverr_o;
  logic trip_o, sync_o, soc_o, irq_o, edge_a_o, edge_b_o;
  logic [7:0] pos_cal_steps_i, fine_cmp_a_o, fine_cmp_b_o, fine_period_o, fine_phase_o;
  logic [7:0] scale = pwm_evt_pkg::POS_NOMINAL; // Expected positioner scale.
  int mismatches = 0, cmp_count = 0, soc_seen = 0;

  always #2 clk_sys_i = ~clk_sys_i;
  // Counts conversion pulses.
  always @(posedge clk_sys_i) if (soc_o === 1'b1) soc_seen++;

  pwm_event_hires uut (.clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .tb_count_i, .tb_tick_i, .tb_up_i, .ext_pin_i, .periph_i, .pos_cal_steps_i,
    .pos_cal_valid_i, .pos_cal_start_o, .trip_o, .sync_o, .soc_o, .irq_o, .edge_a_o, .edge_b_o,
    .fine_cmp_a_o, .fine_cmp_b_o, .fine_period_o, .fine_phase_o);
  pwm_pos_cal_model cal (.clk_sys_i, .rst_i(sys_rst_i), .start_i(pos_cal_start_o), .steps_i(cal_want),
    .delay_i(cal_wait), .cal_steps_o(pos_cal_steps_i), .cal_valid_o(pos_cal_valid_i));

  // ************************************************************
  // Tasks
  // ************************************************************
  // Prints the counts and the verdict, then stops.
  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Compares a seen value with the expected one.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; waits for the answer under a bound.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (n >= 16) begin
      mismatches++;
      print_verdict();
    end else begin
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_sys_i);
    end
  endtask : apb

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // Presents one counter step, then lets its effects settle.
  task tick(input logic [15:0] c, input logic u);
    tb_count_i <= c;
    tb_up_i <= u;
    tb_tick_i <= 1'b1;
    @(posedge clk_sys_i);
    tb_tick_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask : tick

  function automatic logic [7:0] fine(input logic [7:0] f);
    return 8'((16'(f) * 16'(scale)) >> 8);
  endfunction : fine

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rdchk(pwm_evt_pkg::STATUS_OFS, 32'h0);
    rdchk(pwm_evt_pkg::POS_OFS, 32'(scale));
    rdchk(pwm_evt_pkg::IEN_OFS, 32'h0);
    rdchk(pwm_evt_pkg::CTRL_OFS, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, pwm_evt_pkg::STATUS_OFS, 32'hFFFF);
    rdchk(pwm_evt_pkg::STATUS_OFS, 32'h0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, pwm_evt_pkg::CMP_A_OFS + 8'(4 * k), {8'h00, 8'(k * 64), 16'(16 * (k + 1))});
    end
    apb(1'b1, pwm_evt_pkg::PERIOD_OFS, 32'h00FF_0100);
    apb(1'b1, pwm_evt_pkg::PHASE_OFS, 32'h0080_0000);
    repeat (2) @(posedge clk_sys_i);
    check(32'(fine_cmp_a_o), 32'h0);
    check(32'(fine_cmp_b_o), 32'(fine(8'h40)));
    check(32'(fine_period_o), 32'(fine(8'hFF)));
    check(32'(fine_phase_o), 32'(fine(8'h80)));
    // Interrupt channel walks event select codes 1 to 11.
    apb(1'b1, pwm_evt_pkg::IEN_OFS, 32'h1);
    for (int c = 1; c < 12; c++) begin
      cnt = (c == 2) ? 16'h0100 : (c < 4) ? 16'h0 : 16'(16 * ((c - 4) / 2 + 1));
      up = (c < 4) || (c % 2 == 0);
      apb(1'b1, pwm_evt_pkg::ET_CFG_OFS, 32'h110 | 32'(c));
      if (c >= 4) begin
        tick(cnt, !up);
        check(32'(irq_o), 32'h0);
      end
      tick(cnt, up);
      check(32'(irq_o), 32'h1);
      apb(1'b1, pwm_evt_pkg::CLEAR_OFS, 32'h1);
    end
    // Conversion channel prescaler at divide 1, 8 and 15.
    for (int d = 1; d < 16; d += 7) begin
      apb(1'b1, pwm_evt_pkg::ET_CFG_OFS, 32'({1'b1, 4'(d), 4'h1}) << 12);
      soc_seen = 0;
      repeat (d - 1) tick(16'h0, 1'b1);
      check(32'(soc_seen), 32'h0);
      tick(16'h0, 1'b1);
      check(32'(soc_seen), 32'h1);
      repeat (d) tick(16'h0, 1'b1);
      check(32'(soc_seen), 32'h2);
    end
    // Digital compare on a pin and a peripheral input.
    apb(1'b1, pwm_evt_pkg::ET_CFG_OFS, 32'h0);
    apb(1'b1, pwm_evt_pkg::DC_SEL_OFS, 32'h0101);
    apb(1'b1, pwm_evt_pkg::DC_POL_OFS, 32'h0001);
    apb(1'b1, pwm_evt_pkg::CTRL_OFS, 32'h7);
    check(32'(trip_o), 32'h0);
    ext_pin_i <= 8'h01;
    repeat (3) @(posedge clk_sys_i);
    check({29'h0, trip_o, sync_o, soc_o}, 32'h7);
    ext_pin_i <= 8'hFE;
    periph_i <= 8'hFE;
    repeat (3) @(posedge clk_sys_i);
    check(32'(trip_o), 32'h1);
    periph_i <= 8'hFF;
    repeat (3) @(posedge clk_sys_i);
    check(32'(trip_o), 32'h0);
    check(32'(irq_o), 32'h0);
    apb(1'b1, pwm_evt_pkg::IEN_OFS, 32'h2);
    repeat (2) @(posedge clk_sys_i);
    check(32'(irq_o), 32'h1);
    apb(1'b1, pwm_evt_pkg::CLEAR_OFS, 32'h2);
    repeat (2) @(posedge clk_sys_i);
    check(32'(irq_o), 32'h0);
    // Blanking window opened by a zero step; channel 0 follows the compare event.
    apb(1'b1, pwm_evt_pkg::ET_CFG_OFS, 32'h0000_011C);
    apb(1'b1, pwm_evt_pkg::BLANK_OFS, 32'h0000_0028);
    apb(1'b1, pwm_evt_pkg::CTRL_OFS, 32'h0B);
    tick(16'h0, 1'b1);
    ext_pin_i <= 8'h01;
    repeat (3) @(posedge clk_sys_i);
    check(32'(trip_o), 32'h0);
    rdchk(pwm_evt_pkg::STATUS_OFS, 32'h0);
    repeat (40) @(posedge clk_sys_i);
    check(32'(trip_o), 32'h1);
    rdchk(pwm_evt_pkg::STATUS_OFS, 32'h3);
    ext_pin_i <= 8'hFE;
    apb(1'b1, pwm_evt_pkg::CLEAR_OFS, 32'hF);
    // Self-check, slow healthy answer then a prompt faulty one.
    cal_wait <= 8'h05;
    apb(1'b1, pwm_evt_pkg::CTRL_OFS, 32'h20);
    repeat (12) @(posedge clk_sys_i);
    rdchk(pwm_evt_pkg::STATUS_OFS, 32'h4);
    scale = cal_want;
    rdchk(pwm_evt_pkg::POS_OFS, 32'(scale));
    check(32'(fine_cmp_b_o), 32'(fine(8'h40)));
    cal_want <= 8'h40;
    cal_wait <= 8'h00;
    apb(1'b1, pwm_evt_pkg::CTRL_OFS, 32'h20);
    repeat (12) @(posedge clk_sys_i);
    apb(1'b0, pwm_evt_pkg::STATUS_OFS, 32'h0);
    check(32'(rd[3]), 32'h1);
    rdchk(pwm_evt_pkg::POS_OFS, 32'(scale));
    print_verdict();
  end
endmodule : pwm_event_hires_test
